// file: lsd_driver.sv
// Purpose: Multiplexed segment display driver with port pin sharing.
// Assumes: Registers written over a plain strobe port on mclk.
// Notes:   Pin levels are 2-bit codes; the pad ring maps them to voltages.
`timescale 1ns/100ps
`default_nettype none

module lsd_driver #(
  parameter logic [15:0] TICK_DIV_SLOW = 16'h0800,
  parameter logic [15:0] TICK_DIV_FAST = 16'h0400
) (
  input  wire logic                                  mclk,
  input  wire logic                                  rst,
  input  wire logic [lsd_pkg::ADDR_W-1:0]            busAddr,
  input  wire logic [7:0]                            busWdata,
  input  wire logic                                  busWr,
  input  wire logic                                  busRd,
  output var  logic [7:0]                            busRdata,
  output var  logic [lsd_pkg::NUM_COMMON-1:0][1:0]   commonLevel,
  output var  logic [lsd_pkg::NUM_COMMON-1:0]        commonIsPort,
  output var  logic [lsd_pkg::NUM_COMMON-1:0]        commonPortData,
  output var  logic [lsd_pkg::NUM_SEGMENT-1:0][1:0]  segmentLevel,
  output var  logic [lsd_pkg::NUM_SEGMENT-1:0]       segmentIsPort,
  output var  logic [lsd_pkg::NUM_SEGMENT-1:0]       segmentPortData,
  output var  logic [1:0]                            biasMode,
  output var  logic [1:0]                            commonSlot
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [2:0] slotCount(input logic [1:0] duty);
    logic [2:0] n;
    n = 3'h4;
    case (duty)
      lsd_pkg::DUTY_STATIC: n = 3'h1;
      lsd_pkg::DUTY_HALF:   n = 3'h2;
      lsd_pkg::DUTY_THIRD:  n = 3'h3;
      default:              n = 3'h4;
    endcase
    return n;
  endfunction : slotCount

  function automatic logic [1:0] biasOf(input logic [1:0] duty);
    logic [1:0] b;
    b = lsd_pkg::BIAS_THIRD;
    if (duty == lsd_pkg::DUTY_STATIC) begin
      b = lsd_pkg::BIAS_STATIC;
    end else if (duty == lsd_pkg::DUTY_HALF) begin
      b = lsd_pkg::BIAS_HALF;
    end
    return b;
  endfunction : biasOf

  function automatic logic [1:0] commonDrive(input logic sel,
                                             input logic pol,
                                             input logic [1:0] bias);
    logic [1:0] l;
    l = pol ? lsd_pkg::LVL_SUPPLY : lsd_pkg::LVL_REF_THREE;
    if (!sel && bias == lsd_pkg::BIAS_THIRD) begin
      l = pol ? lsd_pkg::LVL_REF_TWO : lsd_pkg::LVL_REF_ONE;
    end else if (!sel && bias == lsd_pkg::BIAS_HALF) begin
      l = lsd_pkg::LVL_REF_ONE;
    end
    return l;
  endfunction : commonDrive

  // select opposes common, deselect stays near it
  function automatic logic [1:0] segmentDrive(input logic on,
                                              input logic pol,
                                              input logic [1:0] bias);
    logic [1:0] l;
    l = pol ? lsd_pkg::LVL_REF_THREE : lsd_pkg::LVL_SUPPLY;
    if (!on && bias == lsd_pkg::BIAS_THIRD) begin
      l = pol ? lsd_pkg::LVL_REF_ONE : lsd_pkg::LVL_REF_TWO;
    end else if (!on) begin
      l = pol ? lsd_pkg::LVL_SUPPLY : lsd_pkg::LVL_REF_THREE;
    end
    return l;
  endfunction : segmentDrive

  // ****************************************************************
  // State
  // ****************************************************************
  lsd_pkg::lsd_state_t stateQ;
  lsd_pkg::lsd_state_t stateD;
  logic                tick;
  logic [15:0]         divSel;

  assign divSel = stateQ.clkSel ? TICK_DIV_FAST : TICK_DIV_SLOW;
  // Not an equality: a switch to the shorter divisor would miss it
  assign tick = (stateQ.presc >= divSel - 16'h0001);

  always_comb begin
    int          reg_i;
    int          s;
    int          pb;
    logic        isPort;
    logic        pData;
    logic        bitOn;
    logic [2:0]  nSlots;
    logic [1:0]  nextSlot;
    logic        nextPol;
    logic [1:0]  bias;
    stateD = stateQ;
    reg_i = 0;
    s = 0;
    pb = 0;
    isPort = 1'b0;
    pData = 1'b0;
    bitOn = 1'b0;
    nSlots = slotCount(stateQ.duty);
    nextSlot = 2'h0;
    nextPol = stateQ.polarity;
    bias = biasOf(stateQ.duty);

    stateD.presc = tick ? '0 : stateQ.presc + 16'h0001;

    // Register writes; unmapped addresses ignored
    if (busWr) begin
      if (busAddr == lsd_pkg::ADDR_CONTROL) begin
        // bits 4 and 0 are not stored
        stateD.enable = busWdata[lsd_pkg::CTL_ENABLE];
        stateD.duty = {busWdata[lsd_pkg::CTL_DUTY_HI],
                       busWdata[lsd_pkg::CTL_DUTY_LO]};
        stateD.peUpper = busWdata[lsd_pkg::CTL_PE_UPPER];
        stateD.peLower = busWdata[lsd_pkg::CTL_PE_LOWER];
        stateD.pdUpper = busWdata[lsd_pkg::CTL_PD_UPPER];
      end else if (busAddr >= lsd_pkg::ADDR_SEG_FIRST &&
                   busAddr <= lsd_pkg::ADDR_SEG_LAST) begin
        reg_i = int'(busAddr - lsd_pkg::ADDR_SEG_FIRST);
        stateD.segData[reg_i] = busWdata;
        // last register keeps only its low nibble
        if (busAddr == lsd_pkg::ADDR_SEG_LAST) begin
          stateD.segData[reg_i] = busWdata & lsd_pkg::LAST_SEG_MASK;
        end
      end else if (busAddr == lsd_pkg::ADDR_PD_MUX) begin
        stateD.portd_bit_mux = busWdata;
      end else if (busAddr == lsd_pkg::ADDR_PE_MUX) begin
        stateD.porte_bit_mux = busWdata;
      end else if (busAddr == lsd_pkg::ADDR_PD_DATA) begin
        stateD.pdData = busWdata;
      end else if (busAddr == lsd_pkg::ADDR_PE_DATA) begin
        stateD.peData = busWdata;
      end else if (busAddr == lsd_pkg::ADDR_TIMEBASE) begin
        stateD.clkSel = busWdata[lsd_pkg::TB_CLKSEL];
      end
    end

    // Register reads, answered one cycle later
    stateD.rdData = 8'h00;
    if (busRd) begin
      if (busAddr == lsd_pkg::ADDR_CONTROL) begin
        stateD.rdData[lsd_pkg::CTL_ENABLE] = stateQ.enable;
        stateD.rdData[lsd_pkg::CTL_DUTY_HI] = stateQ.duty[1];
        stateD.rdData[lsd_pkg::CTL_DUTY_LO] = stateQ.duty[0];
        stateD.rdData[lsd_pkg::CTL_PE_UPPER] = stateQ.peUpper;
        stateD.rdData[lsd_pkg::CTL_PE_LOWER] = stateQ.peLower;
        stateD.rdData[lsd_pkg::CTL_PD_UPPER] = stateQ.pdUpper;
      end else if (busAddr >= lsd_pkg::ADDR_SEG_FIRST &&
                   busAddr <= lsd_pkg::ADDR_SEG_LAST) begin
        reg_i = int'(busAddr - lsd_pkg::ADDR_SEG_FIRST);
        stateD.rdData = stateQ.segData[reg_i];
      end else if (busAddr == lsd_pkg::ADDR_PD_MUX) begin
        stateD.rdData = stateQ.portd_bit_mux;
      end else if (busAddr == lsd_pkg::ADDR_PE_MUX) begin
        stateD.rdData = stateQ.porte_bit_mux;
      end else if (busAddr == lsd_pkg::ADDR_PD_DATA) begin
        stateD.rdData = stateQ.pdData;
      end else if (busAddr == lsd_pkg::ADDR_PE_DATA) begin
        stateD.rdData = stateQ.peData;
      end else if (busAddr == lsd_pkg::ADDR_TIMEBASE) begin
        stateD.rdData[lsd_pkg::TB_CLKSEL] = stateQ.clkSel;
      end
    end

    // step active slots, flip polarity per frame
    if ({1'b0, stateQ.slot} + 3'h1 >= nSlots) begin
      nextSlot = 2'h0;
      nextPol = ~stateQ.polarity;
    end else begin
      nextSlot = stateQ.slot + 2'h1;
    end

    // Pin drive only changes on a slot boundary, though a timebase write
    // that picks the shorter divisor can end the current slot early.
    // settings sampled at slot boundary
    if (tick) begin
      stateD.slot = nextSlot;
      stateD.polarity = nextPol;
      stateD.biasMode = bias;
      // commons beyond duty go to port D
      for (int c = 0; c < lsd_pkg::NUM_COMMON; c++) begin
        isPort = (c >= int'(nSlots));
        stateD.commPort[c] = isPort;
        stateD.commPortData[c] = isPort & stateQ.pdData[c];
        // disabled display pins sit at supply
        if (isPort || !stateQ.enable) begin
          stateD.commLevel[c] = lsd_pkg::LVL_SUPPLY;
        end else begin
          stateD.commLevel[c] = commonDrive(nextSlot == 2'(c),
                                            nextPol, bias);
        end
      end
      for (s = 0; s < lsd_pkg::NUM_SEGMENT; s++) begin
        isPort = 1'b0;
        pData = 1'b0;
        // only segments 27 up are shareable
        // nibble select overrides the bit mux
        if (s >= lsd_pkg::SEG_PD_UPPER_FIRST) begin
          pb = lsd_pkg::PORT_NIBBLE_TOP - (s - lsd_pkg::SEG_PD_UPPER_FIRST);
          isPort = stateQ.pdUpper | stateQ.portd_bit_mux[pb];
          pData = stateQ.pdData[pb];
        end else if (s >= lsd_pkg::SEG_PE_LOWER_FIRST) begin
          pb = lsd_pkg::PORT_LOW_TOP - (s - lsd_pkg::SEG_PE_LOWER_FIRST);
          isPort = stateQ.peLower | stateQ.porte_bit_mux[pb];
          pData = stateQ.peData[pb];
        end else if (s >= lsd_pkg::SEG_PE_UPPER_FIRST) begin
          pb = lsd_pkg::PORT_NIBBLE_TOP - (s - lsd_pkg::SEG_PE_UPPER_FIRST);
          isPort = stateQ.peUpper | stateQ.porte_bit_mux[pb];
          pData = stateQ.peData[pb];
        end
        stateD.segPort[s] = isPort;
        stateD.segPortData[s] = isPort & pData;
        // even segment low nibble, odd segment high
        // slots beyond duty are never indexed
        bitOn = stateQ.segData[s / 2][(s % 2) * lsd_pkg::NIBBLE
                                      + int'(nextSlot)];
        if (isPort || !stateQ.enable) begin
          stateD.segLevel[s] = lsd_pkg::LVL_SUPPLY;
        end else begin
          stateD.segLevel[s] = segmentDrive(bitOn, nextPol, bias);
        end
      end
    end
  end

  // reset clears everything: disabled, quarter duty
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stateQ <= '0;
    end else begin
      stateQ <= stateD;
    end
  end

  assign busRdata = stateQ.rdData;
  assign commonLevel = stateQ.commLevel;
  assign commonIsPort = stateQ.commPort;
  assign commonPortData = stateQ.commPortData;
  assign segmentLevel = stateQ.segLevel;
  assign segmentIsPort = stateQ.segPort;
  assign segmentPortData = stateQ.segPortData;
  assign biasMode = stateQ.biasMode;
  assign commonSlot = stateQ.slot;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence seq_ctrlRead;
    busRd && busAddr == lsd_pkg::ADDR_CONTROL;
  endsequence

  sequence seq_tickOff;
    tick && !stateQ.enable;
  endsequence

  sequence seq_frameEnd;
    tick && ({1'b0, stateQ.slot} + 3'h1 >= slotCount(stateQ.duty));
  endsequence

  a_ctrl_reserved: assert property (
    seq_ctrlRead |=> busRdata[4] == 1'b0 && busRdata[0] == 1'b0)
    else $error("control reserved bits read nonzero");

  a_segdata_read: assert property (
    busRd && busAddr == lsd_pkg::ADDR_SEG_FIRST && !busWr
    |=> busRdata == $past(stateQ.segData[0]))
    else $error("segment data read mismatch");

  a_disabled_supply: assert property (
    seq_tickOff |=> (segmentLevel == '0) && (commonLevel == '0))
    else $error("disabled pins not at supply");

  a_static_ports: assert property (
    tick && stateQ.duty == lsd_pkg::DUTY_STATIC
    |=> commonIsPort == 4'hE)
    else $error("static duty common ports wrong");

  a_nibble_force: assert property (
    tick && stateQ.peUpper |=> segmentIsPort[30:27] == 4'hF)
    else $error("upper port E nibble not forced");

  a_min_segments: assert property (
    $countones(segmentIsPort) <= lsd_pkg::NUM_SEGMENT -
                                 lsd_pkg::MIN_SEGMENTS)
    else $error("fewer than minimum segments");

  a_slot_range: assert property (
    $past(tick) |-> {1'b0, commonSlot} < slotCount($past(stateQ.duty)))
    else $error("slot beyond active commons");

  a_frame_flip: assert property (
    seq_frameEnd |=> commonSlot == 2'h0 &&
                     stateQ.polarity != $past(stateQ.polarity))
    else $error("frame polarity did not alternate");

  a_bias_track: assert property (
    tick |=> biasMode == biasOf($past(stateQ.duty)))
    else $error("bias does not follow duty");

  a_common_select: assert property (
    tick && stateQ.enable && stateQ.duty == lsd_pkg::DUTY_QUARTER
    && stateQ.slot == 2'h3
    |=> commonLevel[0] == (stateQ.polarity ? lsd_pkg::LVL_SUPPLY
                                            : lsd_pkg::LVL_REF_THREE))
    else $error("common zero not selected at slot zero");

  a_presc_bound: assert property (
    $stable(stateQ.clkSel) |-> stateQ.presc < divSel)
    else $error("prescaler ran past its divisor");

  a_third_ports: assert property (
    tick && stateQ.duty == lsd_pkg::DUTY_THIRD
    |=> commonIsPort == 4'h8)
    else $error("third duty common ports wrong");

  a_lower_nibble: assert property (
    tick && stateQ.peLower |=> segmentIsPort[34:31] == 4'hF)
    else $error("lower port E nibble not forced");

  a_pd_nibble: assert property (
    tick && stateQ.pdUpper
    |=> segmentIsPort[38:35] == 4'hF &&
        segmentPortData[35] == $past(stateQ.pdData[7]))
    else $error("upper port D nibble not forced");

endmodule : lsd_driver

`default_nettype wire

// file: lsd_driver_bench.sv
// Purpose: Self-checking bench for the segment display driver.
// Assumes: Short tick divisors so one frame lasts at most 16 cycles.
// Notes:   Pins are judged against a mirror of what software wrote.
`timescale 1ns/100ps
`default_nettype none

module lsd_driver_bench;

  localparam int DIV_SLOW = 4;
  localparam int DIV_FAST = 2;

  logic                                  mclk;
  logic                                  rst;
  logic [lsd_pkg::ADDR_W-1:0]            busAddr;
  logic [7:0]                            busWdata;
  logic                                  busWr;
  logic                                  busRd;
  logic [7:0]                            busRdata;
  logic [lsd_pkg::NUM_COMMON-1:0][1:0]   commonLevel;
  logic [lsd_pkg::NUM_COMMON-1:0]        commonIsPort;
  logic [lsd_pkg::NUM_COMMON-1:0]        commonPortData;
  logic [lsd_pkg::NUM_SEGMENT-1:0][1:0]  segmentLevel;
  logic [lsd_pkg::NUM_SEGMENT-1:0]       segmentIsPort;
  logic [lsd_pkg::NUM_SEGMENT-1:0]       segmentPortData;
  logic [1:0]                            biasMode;
  logic [1:0]                            commonSlot;
  logic [3:0][38:0]                      lit;
  logic [7:0]                            m [0:25];
  int                                    fails;
  int                                    nChecks;
  int                                    seed;

  lsd_driver #(.TICK_DIV_SLOW(16'h0004), .TICK_DIV_FAST(16'h0002)) dut_u (
    .mclk(mclk), .rst(rst), .busAddr(busAddr), .busWdata(busWdata),
    .busWr(busWr), .busRd(busRd), .busRdata(busRdata),
    .commonLevel(commonLevel), .commonIsPort(commonIsPort),
    .commonPortData(commonPortData), .segmentLevel(segmentLevel),
    .segmentIsPort(segmentIsPort), .segmentPortData(segmentPortData),
    .biasMode(biasMode), .commonSlot(commonSlot));

  lsd_glass_panel panel_u (
    .mclk(mclk), .rst(rst), .commonLevel(commonLevel),
    .commonIsPort(commonIsPort), .segmentLevel(segmentLevel),
    .segmentIsPort(segmentIsPort), .lit(lit));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    nChecks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'b1;
    busRd <= 1'b0;
    @(posedge mclk);
    if (a == 8'h00) m[0] = d & 8'hEE;
    else if (a == 8'h14) m[20] = d & 8'h0F;
    else if (a == 8'h19) m[25] = d & 8'h01;
    else if (a <= 8'h18) m[a] = d;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    busAddr <= a;
    busRd <= 1'b1;
    busWr <= 1'b0;
    @(posedge mclk);
    #1;
    chk("rdata", busRdata, a <= 8'h19 ? m[a] : 8'h00);
  endtask : rd

  task automatic idle(input int k);
    busWr <= 1'b0;
    busRd <= 1'b0;
    repeat (k) @(posedge mclk);
    #1;
  endtask : idle

  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    foreach (m[i]) m[i] = 8'h00;
  endtask : do_reset

  // Mirror bit for segment s at common slot c
  function automatic logic segBit(input int s, input int c);
    return m[1 + s / 2][(s % 2) * 4 + c];
  endfunction : segBit

  // Judges every pin against the mirror in the current slot
  task automatic pins();
    int n, sl, c, s, bi, th, ts;
    logic [7:0] ct, mx, dt, e;
    logic nib, isp, b;
    ct = m[0];
    n = (ct[6:5] == 2'h0) ? 4 : int'(ct[6:5]);
    th = int'(ct[6:5] == 2'h0 || ct[6:5] == 2'h3);
    ts = int'(commonSlot);
    sl = int'(commonLevel[ts]);
    chk("bias", 8'(biasMode), th ? 8'h02 : 8'(ct[6:5] == 2'h2));
    chk("slot", 8'(ts < n), 8'h01);
    chk("csel", 8'(ct[7] ? sl % 3 == 0 : sl == 0), 8'h01);
    for (c = 0; c < 4; c++) begin
      chk("cport", 8'(commonIsPort[c]), 8'(c >= n));
      e = 8'(c >= n && m[23][c]);
      chk("cdat", 8'(commonPortData[c]), e);
      e = th ? 8'(sl == 0 ? 2 : 1) : 8'h01;
      if (c < n && c != ts)
        chk("cnon", 8'(commonLevel[c]), ct[7] ? e : 8'h00);
    end
    for (s = 0; s < 39; s++) begin
      bi = s < 35 ? 34 - s : 42 - s;
      nib = s < 31 ? ct[3] : s < 35 ? ct[2] : ct[1];
      mx = s < 35 ? m[22] : m[21];
      dt = s < 35 ? m[24] : m[23];
      isp = s >= 27 && (nib || mx[bi]);
      chk("sport", 8'(segmentIsPort[s]), 8'(isp));
      chk("sdat", 8'(segmentPortData[s]), 8'(isp && dt[bi]));
      b = segBit(s, ts);
      e = b ? 8'(3 - sl) : th ? 8'(sl == 0 ? 1 : 2) : 8'(sl);
      if (!isp)
        chk("slev", 8'(segmentLevel[s]), ct[7] ? e : 8'h00);
    end
  endtask : pins

  // Follows slot stepping, tick spacing and frame polarity
  task automatic watch(input int per);
    int n, gap, prev, prevLvl, last0, k, nChg;
    logic chg;
    n = (m[0][6:5] == 2'h0) ? 4 : int'(m[0][6:5]);
    prev = int'(commonSlot);
    prevLvl = int'(commonLevel[0]);
    gap = -1000;
    last0 = -1;
    nChg = 0;
    for (k = 0; k < 48; k++) begin
      @(posedge mclk);
      #1;
      pins();
      gap++;
      // Static duty never moves the slot; its common flips instead
      chg = (n == 1) ? int'(commonLevel[0]) != prevLvl
                     : int'(commonSlot) != prev;
      prevLvl = int'(commonLevel[0]);
      if (chg) begin
        nChg++;
        chk("step", 8'(commonSlot), 8'((prev + 1) % n));
        if (gap > 0) chk("tick", 8'(gap), 8'(per));
        if (commonSlot == 2'h0) begin
          if (last0 >= 0)
            chk("polar", 8'(commonLevel[0]), 8'(3 - last0));
          last0 = int'(commonLevel[0]);
        end
        prev = int'(commonSlot);
        gap = 0;
      end
    end
    // A stalled prescaler leaves the pins frozen
    chk("ticks", 8'(nChg >= 48 / per - 1), 8'h01);
  endtask : watch

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    busAddr = 8'h00;
    busWdata = 8'h00;
    busWr = 1'b0;
    busRd = 1'b0;
    seed = 69;
    do_reset();
    rd(8'h00);
    idle(12);
    pins();
    $display("test reset done");
    for (int a = 0; a <= 26; a++) wr(8'(a), 8'($random(seed)));
    for (int a = 0; a <= 26; a++) rd(8'(a));
    rd(8'hFF);
    rd(8'h01);
    idle(1);
    chk("stand", busRdata, 8'h00);
    $display("test registers done");
    for (int d = 0; d < 4; d++) begin
      wr(8'h19, 8'h00);
      for (int a = 1; a <= 20; a++) wr(8'(a), 8'($random(seed)));
      wr(8'h17, 8'($random(seed)));
      wr(8'h00, 8'h80 | 8'(d << 5));
      idle(40);
      for (int c = 0; c < (d == 0 ? 4 : d); c++)
        for (int s = 0; s < 39; s++)
          if (!segmentIsPort[s])
            chk("lit", 8'(lit[c][s]), 8'(segBit(s, c)));
      watch(DIV_SLOW);
      $display("test duty %0d done", d);
    end
    for (int i = 0; i < 8; i++) begin
      for (int a = 21; a <= 24; a++) wr(8'(a), 8'($random(seed)));
      wr(8'h00, (8'($random(seed)) & 8'hE0) | 8'(i << 1));
      idle(12);
      pins();
    end
    $display("test port sharing done");
    wr(8'h00, 8'h80);
    wr(8'h19, 8'h01);
    idle(12);
    watch(DIV_FAST);
    $display("test clock select done");
    do_reset();
    rd(8'h00);
    idle(12);
    pins();
    $display("test second reset done");
    summarize();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    $display("watchdog expired");
    summarize();
  end

endmodule : lsd_driver_bench
`default_nettype wire

// file: lsd_glass_panel.sv
// Purpose: Passive glass model; records which pixels see full select.
// Assumes: Level codes 0 and 3 are the two outermost drive levels.
// Notes:   A pixel turns on only when common and segment differ by 3.
`timescale 1ns/100ps
`default_nettype none

module lsd_glass_panel #(
  parameter int NC = lsd_pkg::NUM_COMMON,
  parameter int NS = lsd_pkg::NUM_SEGMENT
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [NC-1:0][1:0]    commonLevel,
  input  wire logic [NC-1:0]         commonIsPort,
  input  wire logic [NS-1:0][1:0]    segmentLevel,
  input  wire logic [NS-1:0]         segmentIsPort,
  output var  logic [NC-1:0][NS-1:0] lit
);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lit <= '0;
    end else begin
      for (int c = 0; c < NC; c++) begin
        for (int s = 0; s < NS; s++) begin
          // Only an outer common level marks its own slot
          if (!commonIsPort[c] && !segmentIsPort[s] &&
              (commonLevel[c] == 2'h0 || commonLevel[c] == 2'h3)) begin
            lit[c][s] <= (commonLevel[c] ^ segmentLevel[s]) == 2'h3;
          end
        end
      end
    end
  end

endmodule : lsd_glass_panel
`default_nettype wire

// file: lsd_pkg.sv
// Purpose: Shared constants and types for the segment display driver.
// Assumes: Byte-wide register port, one clock, 4 commons, 39 segments.
// Notes:   Level codes select which supply or bias reference drives a pin.
`default_nettype none

package lsd_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_COMMON = 4;
  localparam int NUM_SEGMENT = 39;
  localparam int NUM_SEGREG = 20;
  localparam int ADDR_W = 8;
  localparam int PRESC_W = 16;

  // ****************************************************************
  // Register map (byte locations)
  // ****************************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_SEG_FIRST = 8'h01;
  localparam logic [7:0] ADDR_SEG_LAST = 8'h14;
  localparam logic [7:0] ADDR_PD_MUX = 8'h15;
  localparam logic [7:0] ADDR_PE_MUX = 8'h16;
  localparam logic [7:0] ADDR_PD_DATA = 8'h17;
  localparam logic [7:0] ADDR_PE_DATA = 8'h18;
  localparam logic [7:0] ADDR_TIMEBASE = 8'h19;

  // ****************************************************************
  // Control, timebase and last segment register fields
  // ****************************************************************
  localparam int CTL_ENABLE = 7;
  localparam int CTL_DUTY_HI = 6;
  localparam int CTL_DUTY_LO = 5;
  localparam int CTL_PE_UPPER = 3;
  localparam int CTL_PE_LOWER = 2;
  localparam int CTL_PD_UPPER = 1;
  localparam int TB_CLKSEL = 0;
  localparam logic [7:0] LAST_SEG_MASK = 8'h0F;

  // ****************************************************************
  // Duty, bias and drive levels
  // ****************************************************************
  localparam logic [1:0] DUTY_QUARTER = 2'h0;
  localparam logic [1:0] DUTY_STATIC = 2'h1;
  localparam logic [1:0] DUTY_HALF = 2'h2;
  localparam logic [1:0] DUTY_THIRD = 2'h3;
  localparam logic [1:0] BIAS_STATIC = 2'h0;
  localparam logic [1:0] BIAS_HALF = 2'h1;
  localparam logic [1:0] BIAS_THIRD = 2'h2;
  localparam logic [1:0] LVL_SUPPLY = 2'h0;
  localparam logic [1:0] LVL_REF_ONE = 2'h1;
  localparam logic [1:0] LVL_REF_TWO = 2'h2;
  localparam logic [1:0] LVL_REF_THREE = 2'h3;

  // ****************************************************************
  // Shared segment pins
  // ****************************************************************
  localparam int SEG_PE_UPPER_FIRST = 27;
  localparam int SEG_PE_LOWER_FIRST = 31;
  localparam int SEG_PD_UPPER_FIRST = 35;
  localparam int MIN_SEGMENTS = 27;
  localparam int PORT_NIBBLE_TOP = 7;
  localparam int PORT_LOW_TOP = 3;
  localparam int NIBBLE = 4;

  typedef struct packed {
    logic                         enable;
    logic [1:0]                   duty;
    logic                         peUpper;
    logic                         peLower;
    logic                         pdUpper;
    logic [NUM_SEGREG-1:0][7:0]   segData;
    logic [7:0]                   portd_bit_mux;
    logic [7:0]                   porte_bit_mux;
    logic [7:0]                   pdData;
    logic [7:0]                   peData;
    logic                         clkSel;
    logic [PRESC_W-1:0]           presc;
    logic [1:0]                   slot;
    logic                         polarity;
    logic [NUM_COMMON-1:0][1:0]   commLevel;
    logic [NUM_COMMON-1:0]        commPort;
    logic [NUM_COMMON-1:0]        commPortData;
    logic [NUM_SEGMENT-1:0][1:0]  segLevel;
    logic [NUM_SEGMENT-1:0]       segPort;
    logic [NUM_SEGMENT-1:0]       segPortData;
    logic [1:0]                   biasMode;
    logic [7:0]                   rdData;
  } lsd_state_t;

endpackage : lsd_pkg

`default_nettype wire
